// ### pfsf_pkg.sv
// Purpose: Shared constants for the port fault status flag block
// Assumes: Byte-wide registers reached by a simple strobed register port
// Notes:   Offsets, bit positions, widths, counts and reset values are used elsewhere
package pfsf_pkg;

   localparam int          PFSF_ADDR_W        = 8;
   localparam int          PFSF_DATA_W        = 8;

   // Register offsets
   localparam logic [7:0]  PFSF_FAULT_OFS     = 8'h10;
   localparam logic [7:0]  PFSF_IND_OFS       = 8'h11;
   localparam logic [7:0]  PFSF_ERR_OFS       = 8'h13;
   localparam logic [7:0]  PFSF_UNMAPPED_VAL  = 8'h00;

   // Fault register fields
   localparam int          PFSF_OVV_BIT       = 2;
   localparam int          PFSF_BACKV_BIT     = 1;
   localparam int          PFSF_OVC_BIT       = 0;
   localparam int          PFSF_NUM_FAULTS    = 3;

   // Indication register fields
   localparam int          PFSF_BUDGET_BIT    = 7;
   localparam int          PFSF_CC_BIT        = 4;
   localparam int          PFSF_THERMAL_REGULATION_FLAG_BIT      = 3;
   localparam int          PFSF_LOWCUR_BIT    = 2;
   localparam int          PFSF_DETACH_BIT    = 1;
   localparam int          PFSF_PLUGIN_BIT    = 0;
   localparam int          PFSF_NUM_EVENTS    = 3;

   // Error summary register field
   localparam int          PFSF_ERR_BIT       = 0;

   // Reset values
   localparam logic [7:0]  PFSF_FAULT_RST     = 8'h00;
   localparam logic [7:0]  PFSF_IND_RST       = 8'h00;
   localparam logic        PFSF_ERR_RST       = 1'b0;

endpackage

// ### pfsf_sticky_flag.sv
// Purpose: One sticky status flag with clear-on-read and forced clear
// Assumes: All inputs synchronous to clk_i
// Notes:   A set in the clearing cycle always wins
`timescale 1ns/1ns
module pfsf_sticky_flag (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic set_i,
   input  wire logic cond_i,
   input  wire logic rd_clr_i,
   input  wire logic force_clr_i,
   output logic      flag_o
);
   import pfsf_pkg::*;

   logic flag_q;
   logic flag_d;

   always_comb begin
      flag_d = flag_q;
      // Read only clears once the condition has gone away
      if (force_clr_i || (rd_clr_i && !cond_i)) begin
         flag_d = 1'b0;
      end
      if (set_i) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;

endmodule

// ### pfsf_port_fault_flags.sv
// Purpose: Fault and indication status flags of a USB port power switch
// Assumes: Comparator and event inputs are synchronous; events are pulses
// Notes:   Read data is registered; clear-on-read acts on the read strobe
`timescale 1ns/1ns
module pfsf_port_fault_flags #(
   parameter int ADDR_W = pfsf_pkg::PFSF_ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   // Register port
   input  wire logic              reg_rd_i,
   input  wire logic              reg_wr_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   // Comparator levels
   input  wire logic              supply_ov_i,
   input  wire logic              vbus_over_vs_i,
   input  wire logic              vbus_over_vdd_i,
   input  wire logic              ibus_over_ilim_i,
   input  wire logic              ibus_over_r2min_i,
   input  wire logic              cc_region_i,
   input  wire logic              thermal_reg_i,
   // Event pulses
   input  wire logic              budget_done_i,
   input  wire logic              light_load_i,
   input  wire logic              detach_i,
   input  wire logic              plug_in_i,
   // Control
   input  wire logic              port_power_enable_ctl_i,
   input  wire logic              auto_recovery_en_i,
   // Status outputs
   output logic                   alert_n_o,
   output logic                   error_state_o
);
   import pfsf_pkg::*;

   // Offsets are byte values; a narrower address bus would alias them
   if (ADDR_W < 8) begin : g_chk_addr_w
      $error("ADDR_W must be at least 8 to reach the register offsets");
   end

   // Every field position must fit inside the byte-wide registers
   if (PFSF_BUDGET_BIT >= PFSF_DATA_W || PFSF_OVV_BIT >= PFSF_DATA_W) begin : g_chk_fields
      $error("Register field positions exceed the data width");
   end

   logic [PFSF_NUM_FAULTS-1:0] fault_cond;
   logic [PFSF_NUM_FAULTS-1:0] fault_flags;
   logic [PFSF_NUM_EVENTS-1:0] event_set;
   logic [PFSF_NUM_EVENTS-1:0] event_flags;
   logic                       budget_flag;
   logic                       rd_fault;
   logic                       rd_ind;
   logic                       rd_err;
   logic                       wr_err_zero;
   logic                       err_clr;
   logic                       any_fault;
   logic                       err_q;
   logic                       err_d;
   logic                       alert_q;
   logic                       alert_d;
   logic [7:0]                 fault_view;
   logic [7:0]                 ind_view;
   logic [7:0]                 err_view;
   logic [7:0]                 rdata_q;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      addr_hit = (a == ADDR_W'(ofs));
   endfunction

   assign rd_fault    = reg_rd_i && addr_hit(reg_addr_i, PFSF_FAULT_OFS);
   assign rd_ind      = reg_rd_i && addr_hit(reg_addr_i, PFSF_IND_OFS);
   // A read strobe that hits none of these returns zero
   assign rd_err      = reg_rd_i && addr_hit(reg_addr_i, PFSF_ERR_OFS);
   assign wr_err_zero = reg_wr_i && addr_hit(reg_addr_i, PFSF_ERR_OFS)
                        && !reg_wdata_i[PFSF_ERR_BIT];

   // Fault conditions, comparators already carry the 150 mV margin
   always_comb begin
      fault_cond                 = '0;
      fault_cond[PFSF_OVV_BIT]   = supply_ov_i;
      fault_cond[PFSF_BACKV_BIT] = vbus_over_vs_i || vbus_over_vdd_i;
      fault_cond[PFSF_OVC_BIT]   = ibus_over_ilim_i && ibus_over_r2min_i;
   end

   assign any_fault = |fault_cond;

   // Error summary clear sources; auto-recovery clears once fault conditions and fault flags are gone
   assign err_clr = wr_err_zero || !port_power_enable_ctl_i
                    || (auto_recovery_en_i && !any_fault && (fault_flags == '0));

   // Set and condition share one source, so a read mid-fault never clears
   genvar g;
   generate
      for (g = 0; g < PFSF_NUM_FAULTS; g++) begin : g_fault
         pfsf_sticky_flag u_flag (
            .clk_i       (clk_i),
            .srst_i      (srst_i),
            .set_i       (fault_cond[g]),
            .cond_i      (fault_cond[g]),
            .rd_clr_i    (rd_fault),
            .force_clr_i (err_clr),
            .flag_o      (fault_flags[g])
         );
      end
   endgenerate

   // Indication events: plain clear-on-read
   always_comb begin
      event_set                  = '0;
      event_set[PFSF_LOWCUR_BIT] = light_load_i;
      event_set[PFSF_DETACH_BIT] = detach_i;
      event_set[PFSF_PLUGIN_BIT] = plug_in_i;
   end

   generate
      for (g = 0; g < PFSF_NUM_EVENTS; g++) begin : g_event
         pfsf_sticky_flag u_flag (
            .clk_i       (clk_i),
            .srst_i      (srst_i),
            .set_i       (event_set[g]),
            .cond_i      (1'b0),
            .rd_clr_i    (rd_ind),
            .force_clr_i (1'b0),
            .flag_o      (event_flags[g])
         );
      end
   endgenerate

   // Budget done is an indicator only and never raises alert
   pfsf_sticky_flag u_budget (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .set_i       (budget_done_i),
      .cond_i      (1'b0),
      .rd_clr_i    (rd_ind),
      .force_clr_i (1'b0),
      .flag_o      (budget_flag)
   );

   // Error state: a fault in the clearing cycle keeps it set
   always_comb begin
      err_d = err_q;
      if (err_clr) begin
         err_d = 1'b0;
      end
      if (any_fault) begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         err_q <= PFSF_ERR_RST;
      end else begin
         err_q <= err_d;
      end
   end

   // Alert follows the fault and event flags and the live fault conditions, never the error summary bit
   always_comb begin
      alert_d = (|fault_flags) || (|fault_cond) || (|event_flags);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= alert_d;
      end
   end

   always_comb begin
      fault_view                   = PFSF_FAULT_RST;
      fault_view[PFSF_OVV_BIT]     = fault_flags[PFSF_OVV_BIT];
      fault_view[PFSF_BACKV_BIT]   = fault_flags[PFSF_BACKV_BIT];
      fault_view[PFSF_OVC_BIT]     = fault_flags[PFSF_OVC_BIT];
      ind_view                     = PFSF_IND_RST;
      ind_view[PFSF_BUDGET_BIT]    = budget_flag;
      ind_view[PFSF_CC_BIT]        = cc_region_i;
      ind_view[PFSF_THERMAL_REGULATION_FLAG_BIT]      = thermal_reg_i;
      ind_view[PFSF_LOWCUR_BIT]    = event_flags[PFSF_LOWCUR_BIT];
      ind_view[PFSF_DETACH_BIT]    = event_flags[PFSF_DETACH_BIT];
      ind_view[PFSF_PLUGIN_BIT]    = event_flags[PFSF_PLUGIN_BIT];
      // Bits without a field read as zero
      err_view                     = PFSF_UNMAPPED_VAL;
      err_view[PFSF_ERR_BIT]       = err_q;
   end

   // Read data captures pre-clear value, so a read never loses an event
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= PFSF_UNMAPPED_VAL;
      end else if (reg_rd_i) begin
         if (rd_fault) begin
            rdata_q <= fault_view;
         end else if (rd_ind) begin
            rdata_q <= ind_view;
         end else if (rd_err) begin
            rdata_q <= err_view;
         end else begin
            rdata_q <= PFSF_UNMAPPED_VAL;
         end
      end
   end

   assign reg_rdata_o   = rdata_q;
   assign alert_n_o     = !alert_q;
   assign error_state_o = err_q;

endmodule

// ### pfsf_checker_assertions.sv
// Purpose: Port-level checker for the fault flag block
// Assumes: Read data lags its strobe by one edge
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module pfsf_checker
   import pfsf_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       supply_ov_i,
   input wire logic       vbus_over_vs_i,
   input wire logic       vbus_over_vdd_i,
   input wire logic       ibus_over_ilim_i,
   input wire logic       ibus_over_r2min_i,
   input wire logic       cc_region_i,
   input wire logic       thermal_reg_i,
   input wire logic       port_power_enable_ctl_i,
   input wire logic       auto_recovery_en_i,
   input wire logic       alert_n_o,
   input wire logic       error_state_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic rd_f;
   logic fault_c;
   assign rd_f = reg_rd_i && reg_addr_i == PFSF_FAULT_OFS;
   assign fault_c = supply_ov_i || vbus_over_vs_i || vbus_over_vdd_i || (ibus_over_ilim_i && ibus_over_r2min_i);
   sequence s_clr_rd; rd_f && !supply_ov_i; endsequence
   // Host reads come at most every other edge
   sequence s_gap; !supply_ov_i; endsequence
   property p_ovv; supply_ov_i |=> error_state_o; endproperty
   a_ovv: assert property (p_ovv) else $error("error state missing after overvoltage");
   property p_alert; fault_c |=> !alert_n_o; endproperty
   a_alert: assert property (p_alert) else $error("alert missing after fault");
   property p_rclr; s_clr_rd ##1 s_gap ##1 s_clr_rd |=> !reg_rdata_o[PFSF_OVV_BIT]; endproperty
   a_rclr: assert property (p_rclr) else $error("overvoltage flag kept after read");
   property p_backv; (vbus_over_vs_i || vbus_over_vdd_i) ##1 rd_f |=> reg_rdata_o[PFSF_BACKV_BIT]; endproperty
   a_backv: assert property (p_backv) else $error("back-voltage flag missing");
   property p_ovc; (ibus_over_ilim_i && ibus_over_r2min_i) ##1 rd_f |=> reg_rdata_o[PFSF_OVC_BIT]; endproperty
   a_ovc: assert property (p_ovc) else $error("overcurrent flag missing");
   property p_hi0; rd_f |=> reg_rdata_o[7:3] == 5'h00; endproperty
   a_hi0: assert property (p_hi0) else $error("fault register upper bits set");
   property p_live; reg_rd_i && reg_addr_i == PFSF_IND_OFS
      |=> reg_rdata_o[4] == $past(cc_region_i) && reg_rdata_o[3] == $past(thermal_reg_i) && reg_rdata_o[6:5] == 2'h0;
   endproperty
   a_live: assert property (p_live) else $error("indication live bits wrong");
   property p_en; !port_power_enable_ctl_i && !fault_c |=> !error_state_o; endproperty
   a_en: assert property (p_en) else $error("error kept with power enable low");
   property p_hold; error_state_o && !auto_recovery_en_i && port_power_enable_ctl_i
      && !(reg_wr_i && reg_addr_i == PFSF_ERR_OFS && !reg_wdata_i[PFSF_ERR_BIT]) |=> error_state_o;
   endproperty
   a_hold: assert property (p_hold) else $error("error summary cleared by itself");
endmodule

// ### pfsf_host_model.sv
// Purpose: Host side of the strobed register port
// Assumes: Strobes driven at the falling edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ns
module pfsf_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic            rd_o,
   output logic            wr_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'hFF;
      wdata_o = 8'hFF;
   end
   // Error summary is cleared by a zero write from here, or by power enable low or auto-recovery
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      d = rdata_i;
      addr_o = ~a;
   endtask
endmodule

// ### testbench.sv
// Purpose: Directed test of the fault flag block
// Assumes: Host model drives the register port
// Notes:   Pin word is {err, alert_n}
`timescale 1ns/1ns
module testbench;
   import pfsf_pkg::*;
   logic clk_i = 1'b0, srst_i = 1'b1, rd, wr, alert_n, err;
   logic [7:0] addr, wdata, rdata, d;
   logic sov = 1'b0, bvs = 1'b0, bvd = 1'b0, ilim = 1'b0, r2 = 1'b0, cc = 1'b0, tr = 1'b0;
   logic bud = 1'b0, ll = 1'b0, det = 1'b0, plg = 1'b0, en = 1'b1, ar = 1'b0;
   int fail_count = 0;
   int num_checks = 0;
   always #5 clk_i = ~clk_i;
   pfsf_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
   pfsf_port_fault_flags DUT (.clk_i(clk_i), .srst_i(srst_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .supply_ov_i(sov), .vbus_over_vs_i(bvs), .vbus_over_vdd_i(bvd),
      .ibus_over_ilim_i(ilim), .ibus_over_r2min_i(r2), .cc_region_i(cc), .thermal_reg_i(tr),
      .budget_done_i(bud), .light_load_i(ll), .detach_i(det), .plug_in_i(plg), .port_power_enable_ctl_i(en),
      .auto_recovery_en_i(ar), .alert_n_o(alert_n), .error_state_o(err));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      chk("rdata", e, d);
   endtask
   task automatic pins(input logic [7:0] e);
      chk("pins", e, {6'h00, err, alert_n});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      end_sim;
   end
   initial begin
      cyc(16);
      srst_i = 1'b0;
      rdc(PFSF_FAULT_OFS, PFSF_FAULT_RST);
      rdc(PFSF_IND_OFS, PFSF_IND_RST);
      pins(8'h01);
      sov = 1'b1;
      cyc(1);
      sov = 1'b0;
      pins(8'h02);
      rdc(PFSF_FAULT_OFS, 8'h04);
      rdc(PFSF_FAULT_OFS, 8'h00);
      pins(8'h03);
      rdc(PFSF_ERR_OFS, 8'h01);
      host.wr(PFSF_ERR_OFS, 8'h01);
      pins(8'h03);
      host.wr(PFSF_ERR_OFS, 8'h00);
      cyc(1);
      pins(8'h01);
      rdc(PFSF_ERR_OFS, 8'h00);
      // Both comparator inputs, cleared only once the condition is gone
      for (int i = 0; i < 2; i++) begin
         {bvs, bvd} = i ? 2'b01 : 2'b10;
         cyc(1);
         rdc(PFSF_FAULT_OFS, 8'h02);
         rdc(PFSF_FAULT_OFS, 8'h02);
         {bvs, bvd} = 2'b00;
         rdc(PFSF_FAULT_OFS, 8'h02);
         rdc(PFSF_FAULT_OFS, 8'h00);
      end
      host.wr(PFSF_ERR_OFS, 8'h00);
      // Comparators held through the read; only both together set the flag
      for (int i = 1; i < 4; i++) begin
         {ilim, r2} = i[1:0];
         rdc(PFSF_FAULT_OFS, (i == 3) ? 8'h01 : 8'h00);
         {ilim, r2} = 2'b00;
      end
      host.wr(PFSF_ERR_OFS, 8'h00);
      rdc(PFSF_FAULT_OFS, 8'h00);
      {ilim, r2} = 2'b11;
      cyc(1);
      {ilim, r2, en} = 3'b000;
      cyc(2);
      pins(8'h01);
      rdc(PFSF_FAULT_OFS, 8'h00);
      en = 1'b1;
      cc = 1'b1;
      {bud, ll, det, plg} = 4'hF;
      cyc(1);
      {bud, ll, det, plg} = 4'h0;
      cyc(1);
      pins(8'h00);
      rdc(PFSF_IND_OFS, 8'h97);
      {cc, tr} = 2'b01;
      host.wr(PFSF_IND_OFS, 8'hFF);
      rdc(PFSF_IND_OFS, 8'h08);
      rdc(8'h20, PFSF_UNMAPPED_VAL);
      ar = 1'b1;
      sov = 1'b1;
      cyc(1);
      sov = 1'b0;
      rdc(PFSF_FAULT_OFS, 8'h04);
      cyc(2);
      pins(8'h01);
      // Mid-run reset drops every flag and the error summary
      {sov, plg, tr} = 3'b110;
      cyc(1);
      {sov, plg, srst_i} = 3'b001;
      cyc(2);
      srst_i = 1'b0;
      pins(8'h01);
      rdc(PFSF_FAULT_OFS, PFSF_FAULT_RST);
      rdc(PFSF_IND_OFS, PFSF_IND_RST);
      end_sim;
   end
endmodule
bind pfsf_port_fault_flags pfsf_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .reg_rd_i(reg_rd_i),
   .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .supply_ov_i(supply_ov_i), .vbus_over_vs_i(vbus_over_vs_i), .vbus_over_vdd_i(vbus_over_vdd_i),
   .ibus_over_ilim_i(ibus_over_ilim_i), .ibus_over_r2min_i(ibus_over_r2min_i), .cc_region_i(cc_region_i),
   .thermal_reg_i(thermal_reg_i), .port_power_enable_ctl_i(port_power_enable_ctl_i),
   .auto_recovery_en_i(auto_recovery_en_i), .alert_n_o(alert_n_o), .error_state_o(error_state_o));
